// ---- verilog/uart_rate_pkg.sv ----
package uart_rate_pkg;
   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_TX_CTRL = 8'h00;
   localparam logic [7:0] OFS_RX_CTRL = 8'h04;
   localparam logic [7:0] OFS_RATE_CTRL = 8'h08;
   localparam logic [7:0] OFS_DIV_HIGH = 8'h0C;
   localparam logic [7:0] OFS_DIV_LOW = 8'h10;
   localparam logic [7:0] OFS_RX_BUFFER = 8'h14;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int TX_CLK_SRC = 7;
   localparam int TX_SYNC = 4;
   localparam int TX_HIGH_SPEED = 2;
   localparam int TX_SHIFT_EMPTY = 1;
   localparam int RX_PORT_EN = 7;
   localparam int RX_NINE_EN = 6;
   localparam int RX_CONT_EN = 4;
   localparam int RX_FRAMING = 2;
   localparam int RX_OVERRUN = 1;
   localparam int RX_NINTH = 0;
   localparam int RC_ROLLOVER = 7;
   localparam int RC_IDLE = 6;
   localparam int RC_RX_INV = 5;
   localparam int RC_TX_INV = 4;
   localparam int RC_WIDE = 3;
   localparam int RC_WAKE = 1;
   localparam int RC_AUTOBAUD = 0;

   // ------------------------------------------------------------
   // reset values and write masks
   // ------------------------------------------------------------
   localparam logic [7:0] TX_CTRL_RST = 8'h00;
   localparam logic [7:0] RX_CTRL_RST = 8'h00;
   localparam logic [7:0] RATE_CTRL_RST = 8'h00;
   localparam logic [7:0] DIV_HIGH_RST = 8'h00;
   localparam logic [7:0] DIV_LOW_RST = 8'h00;
   localparam logic [7:0] RX_BUFFER_RST = 8'h00;
   localparam logic [7:0] TX_CTRL_WMASK = 8'hFD;
   localparam logic [7:0] RX_CTRL_WMASK = 8'hF8;
   localparam logic [7:0] RATE_CTRL_WMASK = 8'hBB;
   localparam logic [1:0] PIN_IDLE = 2'h3;

   // ------------------------------------------------------------
   // timing counts
   // ------------------------------------------------------------
   // prescales 64, 16, 4 and 4
   localparam logic [6:0] PRESCALE_LOW = 7'h40;
   localparam logic [6:0] PRESCALE_HIGH = 7'h10;
   localparam logic [6:0] PRESCALE_FAST = 7'h04;
   localparam logic [6:0] PRESCALE_SYNC = 7'h04;
   localparam logic [5:0] SCLK_RISE_PHASE = 6'h01;
   localparam logic [3:0] LAST_BIT_8 = 4'h7;
   localparam logic [3:0] LAST_BIT_9 = 4'h8;
   // falling edges of the 55h field after the start edge, minus one
   localparam logic [2:0] AUTOBAUD_LAST_EDGE = 3'h3;
   localparam logic [2:0] AUTOBAUD_UNIT_LOW = 3'h7;
   localparam logic [15:0] ROLL_WIDE = 16'hFFFF;
   localparam logic [15:0] ROLL_NARROW = 16'h00FF;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_START = 5'b00010,
      ST_DATA = 5'b00100,
      ST_STOP = 5'b01000,
      ST_MEASURE = 5'b10000
   } rx_state_t;
endpackage

// ---- verilog/uart_pin_filter.sv ----
`timescale 1ns/100ps
module uart_pin_filter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] pins,
   input wire logic sample,
   output logic [1:0] level,
   output logic vote
);
   logic [1:0] s1;
   logic [1:0] s2;
   logic [1:0] s3;
   logic [1:0] agree;
   logic [1:0] next_level;
   logic [2:0] taps;
   logic [2:0] next_taps;

   // ------------------------------------------------------------
   // level accepted once second and third stage agree
   // ------------------------------------------------------------
   always_comb begin
      agree = ~(s2 ^ s3);
      next_level = (agree & s2) | (~agree & level);
      next_taps = sample ? {taps[1:0], level[0]} : taps;
   end

   // two of three samples decide
   assign vote = (taps[0] & taps[1]) | (taps[0] & taps[2]) | (taps[1] & taps[2]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= uart_rate_pkg::PIN_IDLE;
         s2 <= uart_rate_pkg::PIN_IDLE;
         s3 <= uart_rate_pkg::PIN_IDLE;
         level <= uart_rate_pkg::PIN_IDLE;
         taps <= 3'h7;
      end else begin
         s1 <= pins;
         s2 <= s1;
         s3 <= s2;
         level <= next_level;
         taps <= next_taps;
      end
   end
endmodule // uart_pin_filter

// ---- verilog/uart_rate_status.sv ----
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
module uart_rate_status (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_pin,
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   output logic tx_line,
   output logic wake_event
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic [6:0] prescale(input logic s, input logic w, input logic h);
      if (s) prescale = uart_rate_pkg::PRESCALE_SYNC;
      else if (w && h) prescale = uart_rate_pkg::PRESCALE_FAST;
      else if (w || h) prescale = uart_rate_pkg::PRESCALE_HIGH;
      else prescale = uart_rate_pkg::PRESCALE_LOW;
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] transmit_control_status;
   logic [7:0] receive_control_status;
   logic [7:0] rate_control;
   logic [7:0] divisor_high_byte;
   logic [7:0] divisor_low_byte;
   logic [7:0] rx_buffer;
   logic framing_fault;
   logic overrun_fault;
   logic rx_ninth_bit;
   logic buf_full;
   logic [15:0] rate_cnt;
   logic [5:0] phase;
   uart_rate_pkg::rx_state_t state;
   logic [3:0] bit_cnt;
   logic [8:0] shift;
   logic [15:0] ab_cnt;
   logic [8:0] ab_sub;
   logic [2:0] ab_edges;
   logic rx_prev;
   logic clk_prev;
   logic wake_armed;

   logic [7:0] next_transmit_control_status;
   logic [7:0] next_receive_control_status;
   logic [7:0] next_rate_control;
   logic [7:0] next_divisor_high_byte;
   logic [7:0] next_divisor_low_byte;
   logic [7:0] next_rx_buffer;
   logic next_framing_fault;
   logic next_overrun_fault;
   logic next_rx_ninth_bit;
   logic next_buf_full;
   logic [15:0] next_rate_cnt;
   logic [5:0] next_phase;
   uart_rate_pkg::rx_state_t next_state;
   logic [3:0] next_bit_cnt;
   logic [8:0] next_shift;
   logic [15:0] next_ab_cnt;
   logic [8:0] next_ab_sub;
   logic [2:0] next_ab_edges;
   logic next_rx_prev;
   logic next_clk_prev;
   logic next_wake_armed;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic next_serial_clock_pin_out;
   logic next_serial_clock_pin_oe;
   logic next_tx_line;
   logic next_wake_event;

   // ------------------------------------------------------------
   // decoded controls
   // ------------------------------------------------------------
   logic sync_mode;
   logic master;
   logic wide_divider_sel;
   logic high_speed_sel;
   logic continuous_rx_en;
   logic rx_nine_bit_en;
   logic port_en;
   logic rx_on;
   logic wake_on_edge_en;
   logic autobaud_en;
   logic [15:0] divisor;
   logic [6:0] pre;
   logic [5:0] pre_m1;
   logic [5:0] mid;
   logic tick;
   logic bit_end;
   logic sample;
   logic [1:0] pin_level;
   logic raw_vote;
   logic rx_in;
   logic rx_vote;
   logic clk_in;
   logic rx_fall;
   logic rx_rise;
   logic sclk_rise;
   logic [3:0] last_bit;
   logic [15:0] roll_limit;
   logic [15:0] ab_result;

   assign sync_mode = transmit_control_status[uart_rate_pkg::TX_SYNC];
   assign master = transmit_control_status[uart_rate_pkg::TX_CLK_SRC];
   assign high_speed_sel = transmit_control_status[uart_rate_pkg::TX_HIGH_SPEED];
   assign wide_divider_sel = rate_control[uart_rate_pkg::RC_WIDE];
   assign continuous_rx_en = receive_control_status[uart_rate_pkg::RX_CONT_EN];
   assign rx_nine_bit_en = receive_control_status[uart_rate_pkg::RX_NINE_EN];
   assign port_en = receive_control_status[uart_rate_pkg::RX_PORT_EN];
   assign rx_on = port_en & continuous_rx_en;
   assign wake_on_edge_en = rate_control[uart_rate_pkg::RC_WAKE] & ~sync_mode;
   assign autobaud_en = rate_control[uart_rate_pkg::RC_AUTOBAUD];
   // high byte ignored unless wide
   assign divisor = wide_divider_sel ? {divisor_high_byte, divisor_low_byte} :
      {8'h00, divisor_low_byte};
   assign pre = prescale(sync_mode, wide_divider_sel, high_speed_sel);
   assign pre_m1 = 6'(pre - 7'h01);
   assign mid = pre[6:1];
   assign tick = (rate_cnt == divisor);
   assign bit_end = tick & (phase == pre_m1);
   assign sample = tick & ((phase == 6'(mid - 6'h01)) | (phase == mid) |
      (phase == 6'(mid + 6'h01)));
   assign rx_in = pin_level[0] ^ (rate_control[uart_rate_pkg::RC_RX_INV] & ~sync_mode);
   assign rx_vote = raw_vote ^ (rate_control[uart_rate_pkg::RC_RX_INV] & ~sync_mode);
   assign clk_in = pin_level[1] ^ rate_control[uart_rate_pkg::RC_RX_INV];
   assign rx_fall = rx_prev & ~rx_in;
   assign rx_rise = ~rx_prev & rx_in;
   // master shifts on the internal rise, slave on the external rise
   assign sclk_rise = master ? (tick & (phase == uart_rate_pkg::SCLK_RISE_PHASE)) :
      (clk_in & ~clk_prev);
   assign last_bit = rx_nine_bit_en ? uart_rate_pkg::LAST_BIT_9 : uart_rate_pkg::LAST_BIT_8;
   assign roll_limit = wide_divider_sel ? uart_rate_pkg::ROLL_WIDE : uart_rate_pkg::ROLL_NARROW;
   // count includes the unit that closes in the final cycle
   assign ab_result = (next_ab_cnt == 16'h0000) ? 16'h0000 : 16'(next_ab_cnt - 16'h0001);

   uart_pin_filter u_pin_filter (
      .pclk(pclk),
      .presetn(presetn),
      .pins({serial_clock_pin_in, rx_pin}),
      .sample(sample),
      .level(pin_level),
      .vote(raw_vote)
   );

   // ------------------------------------------------------------
   // apb access
   // ------------------------------------------------------------
   logic setup;
   logic wr;
   logic rd_buf;
   logic div_wr;
   logic mapped;
   logic [7:0] rdata;

   assign setup = psel & ~penable;
   assign wr = psel & penable & pready & pwrite;
   assign rd_buf = psel & penable & pready & ~pwrite & hit(paddr, uart_rate_pkg::OFS_RX_BUFFER);

   always_comb begin
      mapped = 1'b1;
      case (paddr)
         uart_rate_pkg::OFS_TX_CTRL: begin
            rdata = transmit_control_status;
            rdata[uart_rate_pkg::TX_SHIFT_EMPTY] = 1'b1;
         end
         uart_rate_pkg::OFS_RX_CTRL: begin
            rdata = receive_control_status;
            rdata[uart_rate_pkg::RX_FRAMING] = framing_fault;
            rdata[uart_rate_pkg::RX_OVERRUN] = overrun_fault;
            rdata[uart_rate_pkg::RX_NINTH] = rx_ninth_bit;
         end
         uart_rate_pkg::OFS_RATE_CTRL: begin
            rdata = rate_control;
            rdata[uart_rate_pkg::RC_IDLE] = (state == uart_rate_pkg::ST_IDLE);
         end
         uart_rate_pkg::OFS_DIV_HIGH: rdata = divisor_high_byte;
         uart_rate_pkg::OFS_DIV_LOW: rdata = divisor_low_byte;
         uart_rate_pkg::OFS_RX_BUFFER: rdata = rx_buffer;
         default: begin
            rdata = 8'h00;
            mapped = 1'b0;
         end
      endcase
      next_prdata = setup ? {24'h000000, rdata} : prdata;
      next_pready = setup;
      next_pslverr = setup & ~mapped;
   end

   // ------------------------------------------------------------
   // receiver and auto-baud
   // ------------------------------------------------------------
   logic realign;
   logic load;
   logic load_err;
   logic load_ok;
   logic ab_done;
   logic ab_roll;
   logic wake_fall;
   logic wake_clear;

   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_ab_cnt = ab_cnt;
      next_ab_sub = ab_sub;
      next_ab_edges = ab_edges;
      realign = 1'b0;
      load = 1'b0;
      load_err = 1'b0;
      ab_done = 1'b0;
      ab_roll = 1'b0;
      case (state)
         uart_rate_pkg::ST_IDLE: begin
            next_bit_cnt = 4'h0;
            if (sync_mode) begin
               if (rx_on) next_state = uart_rate_pkg::ST_DATA;
            end else if (port_en && autobaud_en && rx_fall) begin
               next_state = uart_rate_pkg::ST_MEASURE;
               realign = 1'b1;
               next_ab_cnt = 16'h0000;
               next_ab_sub = 9'h000;
               next_ab_edges = 3'h0;
            end else if (rx_on && !wake_on_edge_en && rx_fall) begin
               next_state = uart_rate_pkg::ST_START;
               realign = 1'b1;
            end
         end
         uart_rate_pkg::ST_START: begin
            // a high start bit is a glitch
            if (bit_end) next_state = rx_vote ? uart_rate_pkg::ST_IDLE : uart_rate_pkg::ST_DATA;
         end
         uart_rate_pkg::ST_DATA: begin
            if (!rx_on) begin
               next_state = uart_rate_pkg::ST_IDLE;
            end else if (sync_mode ? sclk_rise : bit_end) begin
               next_shift[bit_cnt] = sync_mode ? rx_in : rx_vote;
               next_bit_cnt = 4'(bit_cnt + 4'h1);
               if (bit_cnt == last_bit) begin
                  if (sync_mode) begin
                     load = 1'b1;
                     next_state = uart_rate_pkg::ST_IDLE;
                  end else begin
                     next_state = uart_rate_pkg::ST_STOP;
                  end
               end
            end
         end
         uart_rate_pkg::ST_STOP: begin
            if (bit_end) begin
               load = 1'b1;
               load_err = ~rx_vote;
               next_state = uart_rate_pkg::ST_IDLE;
            end
         end
         uart_rate_pkg::ST_MEASURE: begin
            if (!autobaud_en || sync_mode) begin
               next_state = uart_rate_pkg::ST_IDLE;
            end else begin
               if (ab_sub == {pre_m1, uart_rate_pkg::AUTOBAUD_UNIT_LOW}) begin
                  next_ab_sub = 9'h000;
                  if (ab_cnt == roll_limit) begin
                     ab_roll = 1'b1;
                     next_ab_cnt = 16'h0000;
                  end else begin
                     next_ab_cnt = 16'(ab_cnt + 16'h0001);
                  end
               end else begin
                  next_ab_sub = 9'(ab_sub + 9'h001);
               end
               if (rx_fall) begin
                  next_ab_edges = 3'(ab_edges + 3'h1);
                  if (ab_edges == uart_rate_pkg::AUTOBAUD_LAST_EDGE) begin
                     ab_done = 1'b1;
                     next_state = uart_rate_pkg::ST_IDLE;
                  end
               end
            end
         end
         default: next_state = uart_rate_pkg::ST_IDLE;
      endcase
      next_rx_prev = rx_in;
      next_clk_prev = clk_in;
      wake_fall = wake_on_edge_en & ~wake_armed & rx_fall;
      wake_clear = wake_on_edge_en & wake_armed & rx_rise;
      next_wake_armed = wake_on_edge_en & (wake_armed ? ~rx_rise : rx_fall);
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_comb begin
      load_ok = load & (~buf_full | rd_buf);
      next_transmit_control_status = transmit_control_status;
      if (wr && hit(paddr, uart_rate_pkg::OFS_TX_CTRL))
         next_transmit_control_status = pwdata[7:0] & uart_rate_pkg::TX_CTRL_WMASK;
      next_receive_control_status = receive_control_status;
      if (wr && hit(paddr, uart_rate_pkg::OFS_RX_CTRL))
         next_receive_control_status = pwdata[7:0] & uart_rate_pkg::RX_CTRL_WMASK;
      // set wins over the clear
      next_overrun_fault = (load & ~load_ok) | (overrun_fault & continuous_rx_en);
      next_framing_fault = load_ok ? load_err : framing_fault;
      next_rx_ninth_bit = load_ok ? (next_shift[8] & rx_nine_bit_en) : rx_ninth_bit;
      next_rx_buffer = load_ok ? next_shift[7:0] : rx_buffer;
      next_buf_full = load_ok | (buf_full & ~rd_buf);
      next_rate_control = rate_control;
      if (wr && hit(paddr, uart_rate_pkg::OFS_RATE_CTRL))
         next_rate_control = pwdata[7:0] & uart_rate_pkg::RATE_CTRL_WMASK;
      if (ab_done) next_rate_control[uart_rate_pkg::RC_AUTOBAUD] = 1'b0;
      if (wake_clear) next_rate_control[uart_rate_pkg::RC_WAKE] = 1'b0;
      if (ab_roll) next_rate_control[uart_rate_pkg::RC_ROLLOVER] = 1'b1;
      next_divisor_high_byte = divisor_high_byte;
      next_divisor_low_byte = divisor_low_byte;
      if (wr && hit(paddr, uart_rate_pkg::OFS_DIV_HIGH)) next_divisor_high_byte = pwdata[7:0];
      if (wr && hit(paddr, uart_rate_pkg::OFS_DIV_LOW)) next_divisor_low_byte = pwdata[7:0];
      if (ab_done) begin
         next_divisor_low_byte = ab_result[7:0];
         if (wide_divider_sel) next_divisor_high_byte = ab_result[15:8];
      end
      div_wr = ab_done | (wr && (hit(paddr, uart_rate_pkg::OFS_DIV_HIGH) ||
         hit(paddr, uart_rate_pkg::OFS_DIV_LOW)));
   end

   // ------------------------------------------------------------
   // rate timer and outputs
   // ------------------------------------------------------------
   always_comb begin
      next_rate_cnt = (div_wr | realign | tick) ? 16'h0000 : 16'(rate_cnt + 16'h0001);
      next_phase = phase;
      if (realign) next_phase = 6'h00;
      else if (tick) next_phase = (phase == pre_m1) ? 6'h00 : 6'(phase + 6'h01);
      next_serial_clock_pin_oe = sync_mode & master & port_en;
      next_serial_clock_pin_out = ((state == uart_rate_pkg::ST_DATA) & next_phase[1]) ^
         rate_control[uart_rate_pkg::RC_TX_INV];
      next_tx_line = sync_mode | ~rate_control[uart_rate_pkg::RC_TX_INV];
      next_wake_event = wake_fall;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_control_status <= uart_rate_pkg::TX_CTRL_RST;
         receive_control_status <= uart_rate_pkg::RX_CTRL_RST;
         rate_control <= uart_rate_pkg::RATE_CTRL_RST;
         divisor_high_byte <= uart_rate_pkg::DIV_HIGH_RST;
         divisor_low_byte <= uart_rate_pkg::DIV_LOW_RST;
         rx_buffer <= uart_rate_pkg::RX_BUFFER_RST;
         framing_fault <= 1'b0;
         overrun_fault <= 1'b0;
         rx_ninth_bit <= 1'b0;
         buf_full <= 1'b0;
         rate_cnt <= 16'h0000;
         phase <= 6'h00;
         state <= uart_rate_pkg::ST_IDLE;
         bit_cnt <= 4'h0;
         shift <= 9'h000;
         ab_cnt <= 16'h0000;
         ab_sub <= 9'h000;
         ab_edges <= 3'h0;
         rx_prev <= 1'b1;
         clk_prev <= 1'b1;
         wake_armed <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         serial_clock_pin_out <= 1'b0;
         serial_clock_pin_oe <= 1'b0;
         tx_line <= 1'b1;
         wake_event <= 1'b0;
      end else begin
         transmit_control_status <= next_transmit_control_status;
         receive_control_status <= next_receive_control_status;
         rate_control <= next_rate_control;
         divisor_high_byte <= next_divisor_high_byte;
         divisor_low_byte <= next_divisor_low_byte;
         rx_buffer <= next_rx_buffer;
         framing_fault <= next_framing_fault;
         overrun_fault <= next_overrun_fault;
         rx_ninth_bit <= next_rx_ninth_bit;
         buf_full <= next_buf_full;
         rate_cnt <= next_rate_cnt;
         phase <= next_phase;
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         ab_cnt <= next_ab_cnt;
         ab_sub <= next_ab_sub;
         ab_edges <= next_ab_edges;
         rx_prev <= next_rx_prev;
         clk_prev <= next_clk_prev;
         wake_armed <= next_wake_armed;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         serial_clock_pin_out <= next_serial_clock_pin_out;
         serial_clock_pin_oe <= next_serial_clock_pin_oe;
         tx_line <= next_tx_line;
         wake_event <= next_wake_event;
      end
   end
endmodule // uart_rate_status

// ---- dv/uart_rate_status_assertions.sv ----
`timescale 1ns/100ps
module uart_rate_status_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wake_event,
   input wire logic [31:0] prdata
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   property p_answer; s_setup |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_quiet; s_setup |-> !pready; endproperty
   a_quiet: assert property (p_quiet) else $error("early answer");
   property p_single; pready |=> !pready; endproperty
   a_single: assert property (p_single) else $error("long answer");
   property p_access; pready |-> psel && penable; endproperty
   a_access: assert property (p_access) else $error("stray answer");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("stray error");
   property p_err_data; pslverr |-> prdata == 32'h0; endproperty
   a_err_data: assert property (p_err_data) else $error("refused data");
   property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper bits");
   property p_wake; wake_event |=> !wake_event; endproperty
   a_wake: assert property (p_wake) else $error("long wake");
endmodule // uart_rate_status_assertions
bind uart_rate_status uart_rate_status_assertions u_chk (.pclk, .presetn, .psel, .penable,
   .prdata, .pready, .pslverr, .wake_event);

// ---- dv/uart_line_model.sv ----
`timescale 1ns/100ps
module uart_line_model (
   input wire logic pclk,
   output logic rx
);
   initial rx = 1'b1;
   task automatic send(input logic [8:0] v, input int nb, input logic stop);
      logic [12:0] f;
      f = {3'b111, v, 1'b0};
      f[nb + 1] = stop;
      @(posedge pclk);
      for (int i = 0; i < nb + 3; i++) begin
         rx <= f[i];
         repeat (32) @(posedge pclk);
      end
   endtask
endmodule // uart_line_model

// ---- dv/uart_rate_status_tb_top.sv ----
`timescale 1ns/100ps
module uart_rate_status_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_pin;
   logic serial_clock_pin_out, serial_clock_pin_oe, tx_line, wake_event;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   int num_errors = 0, cmp_count = 0, wake_count = 0;
   uart_rate_status u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .rx_pin, .serial_clock_pin_in(1'b0), .serial_clock_pin_out,
      .serial_clock_pin_oe, .tx_line, .wake_event);
   uart_line_model u_line (.pclk, .rx(rx_pin));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // watchdog far beyond the few thousand cycles the tests take
   initial #100000 complete_run(1'b1);
   always @(negedge pclk) wake_count += (wake_event === 1'b1);
   task automatic complete_run(input logic hung);
      num_errors += hung;
      $display("errors %0d of %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [32:0] seen, input logic [32:0] expected);
      cmp_count++;
      if (seen !== expected) begin
         num_errors++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, expected);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [32:0] got);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      // answer read while it stands before the closing edge
      do @(negedge pclk); while (pready !== 1'b1);
      got = {pslverr, prdata};
      @(posedge pclk);
      {psel, penable} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [32:0] got;
      bus(1'b1, a, {24'h000000, d}, got);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] d);
      logic [32:0] got;
      bus(1'b0, a, 32'h00000000, got);
      check(got, {a > uart_rate_pkg::OFS_RX_BUFFER, 24'h000000, d});
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h08, 8'h40);
      rd(8'h18, 8'h00);
      wr(8'h0C, 8'hFF);
      wr(8'h10, 8'h01);
      wr(8'h00, 8'h04);
      wr(8'h04, 8'h90);
      u_line.send(9'h0A5, 8, 1'b1);
      rd(8'h14, 8'hA5);
      u_line.send(9'h03C, 8, 1'b0);
      rd(8'h04, 8'h94);
      rd(8'h14, 8'h3C);
      u_line.send(9'h011, 8, 1'b1);
      u_line.send(9'h022, 8, 1'b1);
      rd(8'h04, 8'h92);
      rd(8'h14, 8'h11);
      wr(8'h04, 8'h80);
      rd(8'h04, 8'h80);
      wr(8'h04, 8'hD0);
      u_line.send(9'h155, 9, 1'b1);
      rd(8'h04, 8'hD1);
      rd(8'h14, 8'h55);
      wr(8'h10, 8'h07);
      wr(8'h08, 8'h01);
      u_line.send(9'h055, 8, 1'b1);
      rd(8'h10, 8'h01);
      wr(8'h08, 8'h12);
      u_line.send(9'h000, 8, 1'b1);
      check(33'(wake_count), 33'h1);
      rd(8'h08, 8'h50);
      @(negedge pclk);
      check(33'(tx_line), 33'h0);
      wr(8'h04, 8'h80);
      wr(8'h00, 8'h90);
      repeat (2) @(negedge pclk);
      check(33'({serial_clock_pin_oe, serial_clock_pin_out, tx_line}), 33'h7);
      complete_run(1'b0);
   end
endmodule // uart_rate_status_tb_top
